// ---- bof_pkg.sv ----
// Constants, enumerations and carrier types of the beam output packet formatter
package bof_pkg;

  // Packet header constants
  localparam logic [63:0] SPEAD_MAGIC      = 64'h5304401000000008;
  localparam logic [15:0] ITEM_IMMEDIATE   = 16'h8000;
  localparam logic [15:0] ITEM_HEAP_CNT    = 16'h0001;
  localparam logic [15:0] ITEM_PAYLOAD_LEN = 16'h0004;
  localparam logic [15:0] ITEM_REF_TIME    = 16'h1027;
  localparam logic [15:0] ITEM_TIMESTAMP   = 16'h1600;
  localparam logic [15:0] ITEM_CENTER_FREQ = 16'h1011;
  localparam logic [15:0] ITEM_CHAN_INFO   = 16'h3000;
  localparam logic [15:0] ITEM_ANT_INFO    = 16'h3001;
  localparam logic [15:0] ITEM_SAMPLES     = 16'h3300;

  // Field positions inside header items
  localparam int HEAP_CHAN_LSB   = 32;
  localparam int CHINFO_BEAM_LSB = 16;
  localparam int ANT_SUB_LSB     = 32;
  localparam int ANT_STATION_LSB = 16;

  // Physical constants
  localparam logic [31:0] CHAN_SPACING_HZ  = 32'h000BEBC2;
  localparam logic [31:0] HALF_SPACING_HZ  = 32'h0005F5E1;
  localparam logic [39:0] FRAME_PERIOD_NS  = 40'h0000000438;

  // Stream routing codes
  localparam logic [3:0] TID_CHAIN       = 4'h3;
  localparam logic [3:0] TID_CORR_BASE   = 4'h4;
  localparam logic [3:0] TID_CORR_LAST   = 4'hF;
  localparam logic [3:0] DEST_MAX        = 4'hB;
  localparam logic [2:0] TUSER_CHAIN     = 3'h0;
  localparam logic [2:0] TUSER_CORR_BASE = 3'h1;

  // Frame geometry
  localparam logic [4:0]  PKT_LAST_WORD  = 5'h1F;
  localparam logic [2:0]  IN_LAST_PKT    = 3'h7;
  localparam logic [2:0]  MAX_PAR_CHANS  = 3'h4;
  localparam logic [47:0] PKT_BYTES      = 48'h000000000100;
  localparam int          NOF_CHANS      = 4;
  localparam int          MEM_BYTES      = 1024;

  typedef enum logic [3:0] {
    ST_PASS    = 4'h1,
    ST_COLLECT = 4'h2,
    ST_SEND    = 4'h4,
    ST_GAP     = 4'h8
  } bof_state_e;

  typedef struct packed {
    logic [63:0] data;
    logic        last;
    logic [3:0]  id;
    logic [2:0]  user;
  } bof_beat_s;

  typedef struct packed {
    logic [31:0] sync_seconds;
    logic [39:0] start_time_ns;
    logic [3:0]  subarray_index;
    logic [15:0] station;
    logic [9:0]  antenna_count;
    logic [7:0]  first_antenna_index;
    logic [7:0]  channel_count;
    logic [15:0] first_channel_frequency;
    logic [7:0]  tile_module_index;
  } bof_hdr_rec_s;

  typedef logic [8:0][63:0] bof_words_t;

endpackage

// ---- bof_formatter.sv ----
// Beam output packet formatter: header record, routing, requantizer and corner turner
`timescale 1ns/1ps

module bof_formatter (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     srst,
  // Configuration
  input  wire logic                     last_tile,
  input  wire logic [31:0]              ref_seconds,
  input  wire logic [7:0]               subarray_index,
  input  wire logic [15:0]              station_id,
  input  wire logic [7:0]               first_antenna_index,
  input  wire logic [7:0]               tile_module_index,
  input  wire logic [9:0]               local_antenna_count,
  input  wire logic [3:0]               quant_shift,
  input  wire logic [2:0]               parallel_channels,
  input  wire logic [1:0]               start_channel,
  input  wire logic [15:0]              idle_cycles,
  input  wire logic [3:0][3:0]          chan_dest,
  // Input stream from the adder
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [63:0]              in_data,
  input  wire logic                     in_last,
  input  wire logic [15:0]              in_chan_id,
  input  wire logic [31:0]              in_frame,
  input  wire logic [9:0]               in_antennas,
  // Output stream to the packet formatter
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [63:0]                   out_data,
  output logic                          out_last,
  output logic [3:0]                    out_id,
  output logic [2:0]                    out_user,
  // Header for the current output packet
  output bof_pkg::bof_hdr_rec_s         hdr_rec,
  output bof_pkg::bof_words_t           spead_words,
  // Stored packet lookup
  output logic                          ddr_fetch,
  output logic [47:0]                   ddr_fetch_heap,
  // Statistics
  output logic [15:0]                   overflow_count
);

  function automatic logic [8:0] requant(input logic [15:0] s, input logic [3:0] sh);
    logic signed [15:0] v;
    v = $signed(s) >>> sh;
    if (v > 16'sh007F) begin
      requant = {1'b1, 8'h7F};
    end else if (v < -16'sh0080) begin
      requant = {1'b1, 8'h80};
    end else begin
      requant = {1'b0, v[7:0]};
    end
  endfunction

  function automatic logic [1:0] wrap_chan(input logic [3:0] x, input logic [2:0] n);
    logic [3:0] v;
    v = x;
    for (int i = 0; i < 9; i++) begin
      if (v >= {1'b0, n}) begin
        v = v - {1'b0, n};
      end
    end
    wrap_chan = v[1:0];
  endfunction

  bof_pkg::bof_state_e  state;
  bof_pkg::bof_state_e  next_state;
  bof_pkg::bof_beat_s   buf0;
  bof_pkg::bof_beat_s   buf1;
  bof_pkg::bof_beat_s   src_beat;
  logic [1:0]           cnt;
  logic [1:0]           next_cnt;
  logic                 in_first;
  logic [4:0]           col_word;
  logic [2:0]           col_pkt;
  logic [15:0]          base_chan;
  logic [31:0]          col_frame;
  logic [9:0]           col_ant;
  logic [4:0]           send_word;
  logic [1:0]           send_idx;
  logic                 send_done;
  logic [15:0]          gap;
  logic [31:0]          pkt_count;
  logic [7:0]           mem [bof_pkg::MEM_BYTES];

  // Sequencer and buffer control
  wire                  st_pass    = (state == bof_pkg::ST_PASS);
  wire                  st_collect = (state == bof_pkg::ST_COLLECT);
  wire                  st_send    = (state == bof_pkg::ST_SEND);
  wire                  pop        = out_valid & out_ready;
  wire                  room       = (cnt != 2'h2) | pop;
  wire                  take_pass  = st_pass & in_valid & in_ready;
  wire                  take_col   = st_collect & in_valid & in_ready;
  wire                  send_push  = st_send & room;
  wire                  push       = take_pass | send_push;
  wire                  pkt_start  = (take_pass & in_first) | (send_push & send_word == 5'h00);
  wire                  send_end   = send_push & (send_word == bof_pkg::PKT_LAST_WORD);
  wire [2:0]            nch        = (parallel_channels == 3'h0 ||
                                      parallel_channels > bof_pkg::MAX_PAR_CHANS) ?
                                      bof_pkg::MAX_PAR_CHANS : parallel_channels;
  wire [1:0]            rot_ch     = wrap_chan({2'h0, start_channel} + {2'h0, station_id[1:0]}
                                               + {2'h0, send_idx}, nch);
  wire [3:0]            dest       = chan_dest[rot_ch];
  wire [3:0]            corr_tid   = (dest > bof_pkg::DEST_MAX) ? bof_pkg::TID_CORR_LAST :
                                     bof_pkg::TID_CORR_BASE + dest;

  // Requantizer, one lane per channel
  logic [3:0][7:0]      q_lane;
  logic [3:0]           q_ovf;
  logic [63:0]          rd_word;
  logic [15:0]          ovf_add;
  for (genvar c = 0; c < bof_pkg::NOF_CHANS; c++) begin : g_lane
    assign {q_ovf[c], q_lane[c]} = requant(in_data[16*c +: 16], quant_shift);
  end
  for (genvar b = 0; b < 8; b++) begin : g_rd
    assign rd_word[8*b +: 8] = mem[{rot_ch, send_word, 3'(b)}];
  end
  assign ovf_add = {15'h0000, q_ovf[0]} + {15'h0000, q_ovf[1]}
                 + {15'h0000, q_ovf[2]} + {15'h0000, q_ovf[3]};

  // Source beat into the two-entry buffer
  always_comb begin
    if (st_send) begin
      src_beat = '{data: rd_word, last: send_word == bof_pkg::PKT_LAST_WORD, id: corr_tid,
                   user: bof_pkg::TUSER_CORR_BASE + {1'b0, rot_ch}};
    end else begin
      src_beat = '{data: in_data, last: in_last, id: bof_pkg::TID_CHAIN,
                   user: bof_pkg::TUSER_CHAIN};
    end
  end

  assign next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  // Header field values for the packet being started
  wire [15:0]           cur_chan   = st_pass ? in_chan_id : base_chan + {14'h0000, rot_ch};
  wire [31:0]           cur_frame  = st_pass ? in_frame : col_frame;
  wire [9:0]            cur_ant    = (st_pass ? in_antennas : col_ant)
                                     + local_antenna_count;
  wire [8:0]            freq_id    = cur_chan[8:0];
  wire [6:0]            beam_id    = cur_chan[15:9];
  wire [47:0]           heap       = {cur_chan, pkt_count};
  wire [39:0]           ts_ns      = {8'h00, cur_frame} * bof_pkg::FRAME_PERIOD_NS;
  wire [31:0]           chan_freq  = {23'h000000, freq_id} * bof_pkg::CHAN_SPACING_HZ;
  wire [31:0]           cfreq      = chan_freq + bof_pkg::HALF_SPACING_HZ;
  wire [47:0]           chinfo     = {25'h0000000, beam_id, 7'h00, freq_id};
  wire [47:0]           antinfo    = {8'h00, subarray_index, station_id, 6'h00, cur_ant};
  wire                  fill       = ~st_pass;
  bof_pkg::bof_words_t  next_words;
  bof_pkg::bof_hdr_rec_s next_rec;

  assign next_words[0] = bof_pkg::SPEAD_MAGIC;
  assign next_words[1] = {bof_pkg::ITEM_IMMEDIATE | bof_pkg::ITEM_HEAP_CNT, heap};
  assign next_words[2] = {bof_pkg::ITEM_IMMEDIATE | bof_pkg::ITEM_PAYLOAD_LEN,
                          bof_pkg::PKT_BYTES};
  assign next_words[3] = fill ? {bof_pkg::ITEM_IMMEDIATE | bof_pkg::ITEM_REF_TIME,
                                 16'h0000, ref_seconds} : 64'h0;
  assign next_words[4] = fill ? {bof_pkg::ITEM_IMMEDIATE | bof_pkg::ITEM_TIMESTAMP,
                                 8'h00, ts_ns} : 64'h0;
  assign next_words[5] = fill ? {bof_pkg::ITEM_IMMEDIATE | bof_pkg::ITEM_CENTER_FREQ,
                                 16'h0000, cfreq} : 64'h0;
  assign next_words[6] = fill ? {bof_pkg::ITEM_IMMEDIATE | bof_pkg::ITEM_CHAN_INFO,
                                 chinfo} : 64'h0;
  assign next_words[7] = fill ? {bof_pkg::ITEM_IMMEDIATE | bof_pkg::ITEM_ANT_INFO,
                                 antinfo} : 64'h0;
  assign next_words[8] = {bof_pkg::ITEM_SAMPLES, 48'h0};

  assign next_rec = '{sync_seconds: ref_seconds, start_time_ns: ts_ns,
                      subarray_index: subarray_index[3:0], station: station_id,
                      antenna_count: cur_ant, first_antenna_index: first_antenna_index,
                      channel_count: {5'h00, nch}, first_channel_frequency: chan_freq[31:16],
                      tile_module_index: tile_module_index};

  // Next state of the sequencer
  always_comb begin
    case (state)
      bof_pkg::ST_PASS: begin
        next_state = (last_tile & in_first & ~take_pass) ? bof_pkg::ST_COLLECT : bof_pkg::ST_PASS;
      end
      bof_pkg::ST_COLLECT: begin
        if (take_col & in_last & col_pkt == bof_pkg::IN_LAST_PKT) begin
          next_state = bof_pkg::ST_SEND;
        end else if (~last_tile & col_word == 5'h00 & col_pkt == 3'h0 & ~take_col) begin
          next_state = bof_pkg::ST_PASS;
        end else begin
          next_state = bof_pkg::ST_COLLECT;
        end
      end
      bof_pkg::ST_SEND: begin
        next_state = send_end ? bof_pkg::ST_GAP : bof_pkg::ST_SEND;
      end
      bof_pkg::ST_GAP: begin
        if (gap != 16'h0000) begin
          next_state = bof_pkg::ST_GAP;
        end else if (send_done) begin
          next_state = last_tile ? bof_pkg::ST_COLLECT : bof_pkg::ST_PASS;
        end else begin
          next_state = bof_pkg::ST_SEND;
        end
      end
      default: begin
        next_state = bof_pkg::ST_PASS;
      end
    endcase
  end

  // State, buffer occupancy and input ready
  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= bof_pkg::ST_PASS;
      cnt       <= 2'h0;
      out_valid <= 1'b0;
      in_ready  <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      out_valid <= next_cnt != 2'h0;
      in_ready  <= (next_state == bof_pkg::ST_PASS && next_cnt != 2'h2) ||
                   next_state == bof_pkg::ST_COLLECT;
    end
  end

  // Two-entry buffer, head entry drives the output
  always_ff @(posedge clock) begin
    if (srst) begin
      buf0 <= '0;
      buf1 <= '0;
    end else begin
      if (pop) begin
        buf0 <= (cnt == 2'h2) ? buf1 : src_beat;
      end else if (push && cnt == 2'h0) begin
        buf0 <= src_beat;
      end
      if (push && ((cnt == 2'h1 && !pop) || (cnt == 2'h2 && pop))) begin
        buf1 <= src_beat;
      end
    end
  end

  assign out_data = buf0.data;
  assign out_last = buf0.last;
  assign out_id   = buf0.id;
  assign out_user = buf0.user;

  // Input packet framing and corner-turn collection counters
  always_ff @(posedge clock) begin
    if (srst) begin
      in_first  <= 1'b1;
      col_word  <= 5'h00;
      col_pkt   <= 3'h0;
      base_chan <= 16'h0000;
      col_frame <= 32'h00000000;
      col_ant   <= 10'h000;
    end else begin
      if (take_pass) begin
        in_first <= in_last;
      end
      if (take_col) begin
        col_word <= in_last ? 5'h00 : col_word + 5'h01;
        col_pkt  <= in_last ? col_pkt + 3'h1 : col_pkt;
        if (col_word == 5'h00 && col_pkt == 3'h0) begin
          base_chan <= in_chan_id;
          col_frame <= in_frame;
          col_ant   <= in_antennas;
        end
      end
    end
  end

  // Corner-turn memory: one byte per channel per time sample
  always_ff @(posedge clock) begin
    if (take_col) begin
      for (int c = 0; c < bof_pkg::NOF_CHANS; c++) begin
        mem[{2'(c), col_pkt, col_word}] <= q_lane[c];
      end
    end
  end

  // Output sequencer counters
  always_ff @(posedge clock) begin
    if (srst) begin
      send_word <= 5'h00;
      send_idx  <= 2'h0;
      send_done <= 1'b0;
      gap       <= 16'h0000;
    end else begin
      if (send_push) begin
        send_word <= send_word + 5'h01;
      end
      if (send_end) begin
        send_done <= ({1'b0, send_idx} + 3'h1 == nch);
        send_idx  <= ({1'b0, send_idx} + 3'h1 == nch) ? 2'h0 : send_idx + 2'h1;
        gap       <= idle_cycles;
      end else if (gap != 16'h0000) begin
        gap <= gap - 16'h0001;
      end
    end
  end

  // Header registers, packet count, lookup strobe and statistics
  always_ff @(posedge clock) begin
    if (srst) begin
      pkt_count      <= 32'h00000000;
      spead_words    <= '0;
      hdr_rec        <= '0;
      ddr_fetch      <= 1'b0;
      ddr_fetch_heap <= 48'h0;
      overflow_count <= 16'h0000;
    end else begin
      ddr_fetch <= take_pass & in_first;
      if (take_pass && in_first) begin
        ddr_fetch_heap <= heap;
      end
      if (pkt_start) begin
        pkt_count   <= pkt_count + 32'h00000001;
        spead_words <= next_words;
        hdr_rec     <= next_rec;
      end
      if (take_col && overflow_count + ovf_add >= overflow_count) begin
        overflow_count <= overflow_count + ovf_add;
      end
    end
  end

endmodule // bof_formatter

// ---- bof_sink.sv ----
// Model of the downstream header and packet formatter
`timescale 1ns/1ps

module bof_sink (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Back-pressure control
  input  wire logic       stall,
  // Stream from the formatter
  input  wire logic       valid,
  input  wire logic [3:0] id,
  output logic            ready,
  // Count of unroutable indexes
  output logic [7:0]      bad_ids
);
  logic [2:0] phase;

  always_ff @(posedge clock) begin
    if (srst) begin
      phase   <= 3'h0;
      bad_ids <= 8'h00;
    end else begin
      phase <= phase + 3'h1;
      if (valid && ready && (id < bof_pkg::TID_CHAIN)) begin
        bad_ids <= bad_ids + 8'h01;
      end
    end
  end

  // Slow mode accepts on two cycles in eight
  assign ready = !stall || (phase[2:1] == 2'h3);
endmodule // bof_sink

// ---- bof_formatter_properties.sv ----
// Concurrent checks on the formatter ports
`timescale 1ns/1ps

module bof_formatter_properties (
  // Clock, reset and mode
  input wire logic                clock,
  input wire logic                srst,
  input wire logic                last_tile,
  input wire logic [31:0]         ref_seconds,
  // Input stream
  input wire logic                in_valid,
  input wire logic                in_ready,
  input wire logic [15:0]         in_chan_id,
  // Output stream and header
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire logic [63:0]         out_data,
  input wire logic                out_last,
  input wire logic [3:0]          out_id,
  input wire logic [2:0]          out_user,
  input wire bof_pkg::bof_words_t spead_words,
  input wire logic                ddr_fetch,
  input wire logic [47:0]         ddr_fetch_heap
);
  logic [31:0] prev_cnt;
  logic        have_cnt;

  always_ff @(posedge clock) begin
    if (srst) begin
      have_cnt <= 1'b0;
      prev_cnt <= 32'h0;
    end else if (ddr_fetch) begin
      have_cnt <= 1'b1;
      prev_cnt <= ddr_fetch_heap[31:0];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_chain_route: assert property (out_valid && !last_tile |->
    out_id == bof_pkg::TID_CHAIN && out_user == bof_pkg::TUSER_CHAIN)
    else $error("chain beat misrouted");
  a_corr_route: assert property (out_valid && last_tile |->
    out_id >= bof_pkg::TID_CORR_BASE && out_user inside {[3'h1:3'h4]})
    else $error("correlator beat misrouted");
  a_magic_word: assert property (out_valid |->
    spead_words[0] == bof_pkg::SPEAD_MAGIC)
    else $error("header word zero wrong");
  a_fetch_pulse: assert property (ddr_fetch |=> !ddr_fetch)
    else $error("fetch pulse too long");
  a_heap_chan: assert property (ddr_fetch |->
    $past(in_valid && in_ready) && ddr_fetch_heap[47:32] == $past(in_chan_id))
    else $error("heap channel wrong");
  a_heap_words: assert property (ddr_fetch |->
    spead_words[1][47:0] == ddr_fetch_heap && spead_words[3] == 64'h0)
    else $error("chain header words wrong");
  a_heap_step: assert property (ddr_fetch && have_cnt |->
    ddr_fetch_heap[31:0] == prev_cnt + 32'h1)
    else $error("packet count gap");
  a_ref_time: assert property (out_valid && last_tile |->
    spead_words[3][31:0] == ref_seconds)
    else $error("reference time wrong");
  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled beat changed");
  a_corr_gap: assert property (out_valid && out_ready && out_last && last_tile |=>
    !out_valid [*2])
    else $error("no idle gap after packet");
endmodule // bof_formatter_properties

bind bof_formatter bof_formatter_properties bof_formatter_properties_inst (
  .clock(clock), .srst(srst), .last_tile(last_tile), .ref_seconds(ref_seconds),
  .in_valid(in_valid), .in_ready(in_ready), .in_chan_id(in_chan_id),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .out_last(out_last), .out_id(out_id), .out_user(out_user),
  .spead_words(spead_words), .ddr_fetch(ddr_fetch), .ddr_fetch_heap(ddr_fetch_heap));

// ---- bof_formatter_test.sv ----
// Self-checking testbench of the beam output packet formatter
`timescale 1ns/1ps

module bof_formatter_test;
  logic clock, srst, last_tile, in_valid, in_last, stall, in_ready;
  logic out_valid, out_ready, out_last, ddr_fetch, first;
  logic [31:0] ref_seconds, in_frame;
  logic [7:0] subarray_index, first_antenna_index, tile_module_index, bad_ids;
  logic [15:0] station_id, idle_cycles, in_chan_id, overflow_count;
  logic [9:0] local_antenna_count, in_antennas;
  logic [3:0] quant_shift, out_id;
  logic [2:0] parallel_channels, out_user;
  logic [1:0] start_channel;
  logic [3:0][3:0] chan_dest;
  logic [63:0] in_data, out_data;
  logic [47:0] ddr_fetch_heap;
  bof_pkg::bof_hdr_rec_s hdr_rec;
  bof_pkg::bof_words_t spead_words;
  bof_pkg::bof_beat_s rx_q[$];
  bof_pkg::bof_words_t hdr_q[$];
  bof_pkg::bof_hdr_rec_s rec_q[$];
  int miscompares, n_checks, cycles;

  bof_formatter bof_formatter_inst (.clock(clock), .srst(srst), .last_tile(last_tile),
    .ref_seconds(ref_seconds), .subarray_index(subarray_index), .station_id(station_id),
    .first_antenna_index(first_antenna_index), .tile_module_index(tile_module_index),
    .local_antenna_count(local_antenna_count), .quant_shift(quant_shift),
    .parallel_channels(parallel_channels), .start_channel(start_channel),
    .idle_cycles(idle_cycles), .chan_dest(chan_dest), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_last(in_last), .in_chan_id(in_chan_id),
    .in_frame(in_frame), .in_antennas(in_antennas), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last), .out_id(out_id),
    .out_user(out_user), .hdr_rec(hdr_rec), .spead_words(spead_words),
    .ddr_fetch(ddr_fetch), .ddr_fetch_heap(ddr_fetch_heap), .overflow_count(overflow_count));
  bof_sink bof_sink_inst (.clock(clock), .srst(srst), .stall(stall), .valid(out_valid),
    .id(out_id), .ready(out_ready), .bad_ids(bad_ids));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Capture accepted beats and the header seen with each first beat
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (srst) begin
      first <= 1'b1;
    end else if (out_valid && out_ready) begin
      rx_q.push_back('{out_data, out_last, out_id, out_user});
      if (first) begin
        hdr_q.push_back(spead_words);
        rec_q.push_back(hdr_rec);
      end
      first <= out_last;
    end
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic do_reset(input logic tile);
    @(posedge clock);
    srst <= 1'b1;
    last_tile <= tile;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rx_q.delete();
    hdr_q.delete();
    rec_q.delete();
    @(posedge clock);
  endtask

  task automatic send_beat(input logic [63:0] d, input logic l);
    int n;
    in_valid <= 1'b1;
    in_data <= d;
    in_last <= l;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (in_ready !== 1'b1 && n < 2000);
  endtask

  task automatic wait_rx(input int n);
    int t;
    t = 0;
    while (rx_q.size() < n && t < 5000) begin
      @(posedge clock);
      t++;
    end
    check(72'(rx_q.size()), 72'(n));
  endtask

  // Two back-to-back pass-through packets under back-pressure
  task automatic chain_test();
    do_reset(1'b0);
    stall <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      in_chan_id <= 16'h0100 + 16'(p);
      for (int w = 0; w < 3; w++) send_beat({p[7:0], 48'h0, w[7:0]}, w == 2);
    end
    in_valid <= 1'b0;
    wait_rx(6);
    for (int i = 0; i < 6; i++) begin
      check(rx_q[i], {8'(i / 3), 48'h0, 8'(i % 3), i % 3 == 2, 4'h3, 3'h0});
    end
    for (int p = 0; p < 2; p++) begin
      check(72'(hdr_q[p][1][47:32]), 72'(16'h0100 + p));
      check(72'(hdr_q[p][2]), 72'({16'h8004, 48'h100}));
      check(72'(hdr_q[p][8]), 72'({16'h3300, 48'h0}));
      check(72'(hdr_q[p][4] | hdr_q[p][5] | hdr_q[p][6] | hdr_q[p][7]), 72'(0));
    end
  endtask

  // Eight packets corner-turned into n rotated, requantized packets
  task automatic corr_test(input int n, input logic [1:0] sc);
    logic [63:0] e;
    int ch, v;
    do_reset(1'b1);
    stall <= 1'b0;
    parallel_channels <= 3'(n);
    start_channel <= sc;
    for (int p = 0; p < 8; p++) begin
      for (int w = 0; w < 32; w++) begin
        send_beat({16'h0400, 16'(p), 16'hFFFF - 16'(w), 16'(w)}, w == 31);
      end
    end
    in_valid <= 1'b0;
    wait_rx(32 * n);
    for (int k = 0; k < n; k++) begin
      ch = (sc + 1 + k) % n;
      for (int j = 0; j < 32; j++) begin
        for (int b = 0; b < 8; b++) begin
          v = (j % 4) * 8 + b;
          case (ch)
            0: e[8*b +: 8] = 8'(v);
            1: e[8*b +: 8] = 8'(255 - v);
            2: e[8*b +: 8] = 8'(j / 4);
            default: e[8*b +: 8] = 8'h7F;
          endcase
        end
        check(rx_q[k*32+j], {e, j == 31, (ch == 3) ? 4'hF : 4'(4 + ch), 3'(ch + 1)});
      end
      check(72'(hdr_q[k][5][47:0]), 72'(781250 * (5 + ch) + 390625));
      check(72'(rec_q[k].channel_count), 72'(n));
      check(72'(rec_q[k].first_channel_frequency), 72'((781250 * (5 + ch)) >> 16));
      check(72'(hdr_q[k][6][31:0]), 72'({16'h0001, 16'(5 + ch)}));
      check(72'(hdr_q[k][7][39:0]), 72'({8'h03, 16'h0001, 16'h0010}));
      check(72'(hdr_q[k][4][47:0]), 72'(40'h4380));
      check({rec_q[k].sync_seconds, rec_q[k].start_time_ns}, {32'h5A5A0001, 40'h4380});
      check(72'({rec_q[k].subarray_index, rec_q[k].station, rec_q[k].antenna_count,
        rec_q[k].first_antenna_index, rec_q[k].tile_module_index}),
        72'({4'h3, 16'h0001, 10'h010, 8'h20, 8'h07}));
    end
    check(72'(overflow_count), 72'(16'h0100));
    check(72'(bad_ids), 72'(8'h00));
  endtask

  initial begin
    cycles = 0;
    miscompares = 0;
    n_checks = 0;
    srst = 1'b1;
    last_tile = 1'b0;
    stall = 1'b0;
    in_valid = 1'b0;
    in_last = 1'b0;
    in_data = 64'h0;
    ref_seconds = 32'h5A5A0001;
    subarray_index = 8'h03;
    station_id = 16'h0001;
    first_antenna_index = 8'h20;
    tile_module_index = 8'h07;
    local_antenna_count = 10'h001;
    quant_shift = 4'h0;
    parallel_channels = 3'h4;
    start_channel = 2'h0;
    idle_cycles = 16'h0003;
    chan_dest = {4'hC, 4'h2, 4'h1, 4'h0};
    in_chan_id = 16'h0205;
    in_frame = 32'h00000010;
    in_antennas = 10'h00F;
    chain_test();
    in_chan_id <= 16'h0205;
    corr_test(4, 2'h0);
    corr_test(3, 2'h3);
    corr_test(1, 2'h3);
    give_verdict();
  end
endmodule // bof_formatter_test
